//--- src/ipr_map.vh
`ifndef IPR_MAP_VH
`define IPR_MAP_VH

// register byte offsets
`define IPR_OFS_GROUP_TWO 8'h00
`define IPR_OFS_GROUP_THREE 8'h04
`define IPR_OFS_GROUP_FOUR 8'h08
`define IPR_OFS_GROUP_FIVE 8'h0C
`define IPR_OFS_GROUP_SIX 8'h10
`define IPR_OFS_GROUP_SEVEN 8'h14
`define IPR_OFS_ENABLE 8'h18
`define IPR_NUM_REGS 7

// implemented bits of each register
`define IPR_MASK_GROUP_TWO 32'h00007777
`define IPR_MASK_GROUP_THREE 32'h00000077
`define IPR_MASK_GROUP_FOUR 32'h00007777
`define IPR_MASK_GROUP_FIVE 32'h00007707
`define IPR_MASK_GROUP_SIX 32'h00007770
`define IPR_MASK_GROUP_SEVEN 32'h00007777
`define IPR_MASK_ENABLE 32'h000FFFFF

// reset values, every priority field at level 4, every enable bit clear
`define IPR_RST_GROUP_TWO 32'h00004444
`define IPR_RST_GROUP_THREE 32'h00000044
`define IPR_RST_GROUP_FOUR 32'h00004444
`define IPR_RST_GROUP_FIVE 32'h00004404
`define IPR_RST_GROUP_SIX 32'h00004440
`define IPR_RST_GROUP_SEVEN 32'h00004444
`define IPR_RST_ENABLE 32'h00000000

// field lsb in the flat image {seven,six,five,four,three,two}, 16 bits each
`define IPR_POS_SERIAL1_RECEIVE 7'd12
`define IPR_POS_SPI_ONE_EVENT 7'd8
`define IPR_POS_SPI_ONE_FAULT 7'd4
`define IPR_POS_TIMER_THREE 7'd0
`define IPR_POS_ADC_DONE 7'd20
`define IPR_POS_SERIAL1_TRANSMIT 7'd16
`define IPR_POS_CHANGE_NOTIFY 7'd44
`define IPR_POS_COMPARATOR 7'd40
`define IPR_POS_I2C_ONE_MASTER 7'd36
`define IPR_POS_I2C_ONE_SLAVE 7'd32
`define IPR_POS_CAPTURE_EIGHT 7'd60
`define IPR_POS_CAPTURE_SEVEN 7'd56
`define IPR_POS_EXT_PIN_ONE 7'd48
`define IPR_POS_TIMER_FOUR 7'd76
`define IPR_POS_COMPARE_FOUR 7'd72
`define IPR_POS_COMPARE_THREE 7'd68
`define IPR_POS_SERIAL2_TRANSMIT 7'd92
`define IPR_POS_SERIAL2_RECEIVE 7'd88
`define IPR_POS_EXT_PIN_TWO 7'd84
`define IPR_POS_TIMER_FIVE 7'd80
`define IPR_NUM_SRC 20
`define IPR_FIELD_OFF 3'h0

// bus responses
`define IPR_RESP_OKAY 2'h0
`define IPR_RESP_SLVERR 2'h2

`endif

//--- src/ipr_regs.v
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ipr_map.vh"

module ipr_regs (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [19:0] src_flag,
	output wire [59:0] src_level,
	output wire [19:0] src_req
);

	// implemented-bit mask per register index
	function [31:0] reg_mask;
		input [2:0] idx;
		begin
			case (idx)
				3'h0: reg_mask = `IPR_MASK_GROUP_TWO;
				3'h1: reg_mask = `IPR_MASK_GROUP_THREE;
				3'h2: reg_mask = `IPR_MASK_GROUP_FOUR;
				3'h3: reg_mask = `IPR_MASK_GROUP_FIVE;
				3'h4: reg_mask = `IPR_MASK_GROUP_SIX;
				3'h5: reg_mask = `IPR_MASK_GROUP_SEVEN;
				3'h6: reg_mask = `IPR_MASK_ENABLE;
				default: reg_mask = 32'h00000000;
			endcase
		end
	endfunction

	// power-on value per register index
	function [31:0] reg_reset;
		input [2:0] idx;
		begin
			case (idx)
				3'h0: reg_reset = `IPR_RST_GROUP_TWO;
				3'h1: reg_reset = `IPR_RST_GROUP_THREE;
				3'h2: reg_reset = `IPR_RST_GROUP_FOUR;
				3'h3: reg_reset = `IPR_RST_GROUP_FIVE;
				3'h4: reg_reset = `IPR_RST_GROUP_SIX;
				3'h5: reg_reset = `IPR_RST_GROUP_SEVEN;
				3'h6: reg_reset = `IPR_RST_ENABLE;
				default: reg_reset = 32'h00000000;
			endcase
		end
	endfunction

	// field position of each source in the flat priority image
	function [6:0] src_pos;
		input integer s;
		begin
			case (s)
				0: src_pos = `IPR_POS_SERIAL1_RECEIVE;
				1: src_pos = `IPR_POS_SPI_ONE_EVENT;
				2: src_pos = `IPR_POS_SPI_ONE_FAULT;
				3: src_pos = `IPR_POS_TIMER_THREE;
				4: src_pos = `IPR_POS_ADC_DONE;
				5: src_pos = `IPR_POS_SERIAL1_TRANSMIT;
				6: src_pos = `IPR_POS_CHANGE_NOTIFY;
				7: src_pos = `IPR_POS_COMPARATOR;
				8: src_pos = `IPR_POS_I2C_ONE_MASTER;
				9: src_pos = `IPR_POS_I2C_ONE_SLAVE;
				10: src_pos = `IPR_POS_CAPTURE_EIGHT;
				11: src_pos = `IPR_POS_CAPTURE_SEVEN;
				12: src_pos = `IPR_POS_EXT_PIN_ONE;
				13: src_pos = `IPR_POS_TIMER_FOUR;
				14: src_pos = `IPR_POS_COMPARE_FOUR;
				15: src_pos = `IPR_POS_COMPARE_THREE;
				16: src_pos = `IPR_POS_SERIAL2_TRANSMIT;
				17: src_pos = `IPR_POS_SERIAL2_RECEIVE;
				18: src_pos = `IPR_POS_EXT_PIN_TWO;
				19: src_pos = `IPR_POS_TIMER_FIVE;
				default: src_pos = 7'd0;
			endcase
		end
	endfunction

	// register bank and bus state
	reg [31:0] bank_q [0:`IPR_NUM_REGS-1];
	reg awready_q;
	reg wready_q;
	reg aw_have_q;
	reg w_have_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg arready_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	reg [19:0] req_q;
	reg [19:0] req_d;
	integer k;
	integer j;

	// write channel bookkeeping
	wire aw_take = s_axi_awvalid & awready_q;
	wire w_take = s_axi_wvalid & wready_q;
	wire aw_full = aw_have_q | aw_take;
	wire w_full = w_have_q | w_take;
	wire do_wr = aw_full & w_full & ~bvalid_q;
	wire [7:0] wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_have_q ? wdata_q : s_axi_wdata;
	wire [3:0] wr_strb = w_have_q ? wstrb_q : s_axi_wstrb;
	wire [2:0] wr_idx = wr_addr[4:2];
	wire wr_hit = (wr_addr[7:5] == 3'h0) & (wr_idx < `IPR_NUM_REGS) & (wr_addr[1:0] == 2'h0);
	wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire [31:0] wr_mask = reg_mask(wr_idx) & strb_mask;
	wire aw_have_d = aw_full & ~do_wr;
	wire w_have_d = w_full & ~do_wr;
	wire bvalid_d = do_wr | (bvalid_q & ~s_axi_bready);

	// read channel bookkeeping
	wire ar_take = s_axi_arvalid & arready_q;
	wire [2:0] rd_idx = s_axi_araddr[4:2];
	wire rd_hit = (s_axi_araddr[7:5] == 3'h0) & (rd_idx < `IPR_NUM_REGS) & (s_axi_araddr[1:0] == 2'h0);
	wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);

	// write address and data capture, either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awready_q <= ~aw_have_d & ~bvalid_d;
			wready_q <= ~w_have_d & ~bvalid_d;
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// write response, error for unmapped address
	always @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `IPR_RESP_OKAY;
		end else begin
			bvalid_q <= bvalid_d;
			if (do_wr) begin
				bresp_q <= wr_hit ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
			end
		end
	end

	// register bank, unimplemented bits never stored
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (k = 0; k < `IPR_NUM_REGS; k = k + 1) begin
				bank_q[k] <= reg_reset(k[2:0]);
			end
		end else if (do_wr & wr_hit) begin
			bank_q[wr_idx] <= (bank_q[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
		end
	end

	// read path, one word per access
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `IPR_RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			arready_q <= ~rvalid_d;
			if (ar_take) begin
				rdata_q <= rd_hit ? (bank_q[rd_idx] & reg_mask(rd_idx)) : 32'h00000000;
				rresp_q <= rd_hit ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
			end
		end
	end

	// flat image of the six priority registers
	wire [95:0] prio_flat = {bank_q[5][15:0], bank_q[4][15:0], bank_q[3][15:0],
		bank_q[2][15:0], bank_q[1][15:0], bank_q[0][15:0]};
	wire [19:0] src_enable = bank_q[6][19:0];

	// per-source level, field value is the level itself
	genvar g;
	generate
		for (g = 0; g < `IPR_NUM_SRC; g = g + 1) begin : gen_src
			localparam [6:0] POS = src_pos(g);
			assign src_level[3*g +: 3] = prio_flat[POS +: 3];
		end
	endgenerate

	// request gating by enable and nonzero level
	always @* begin
		req_d = 20'h00000;
		// own loop index, the reset loop keeps k to itself
		for (j = 0; j < `IPR_NUM_SRC; j = j + 1) begin
			req_d[j] = src_flag[j] & src_enable[j]
				& (src_level[3*j +: 3] != `IPR_FIELD_OFF);
		end
	end

	// registered requests
	always @(posedge aclk) begin
		if (!aresetn) begin
			req_q <= 20'h00000;
		end else begin
			req_q <= req_d;
		end
	end

	// port drive
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign src_req = req_q;

endmodule // ipr_regs
`default_nettype wire

//--- tb/ipr_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ipr_regs_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic [19:0] src_flag,
	input wire logic [59:0] src_level,
	input wire logic [19:0] src_req
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [19:0] live;
	// sources allowed to request on the next cycle
	always_comb
		for (int i = 0; i < 20; i++) live[i] = src_flag[i] && src_level[3*i+:3] != 3'h0;
	property p_req; (src_req & ~$past(live)) == 20'h0; endproperty
	a_req: assert property (p_req) else $error("request without flag or level");
	property p_rst; $rose(aresetn) |-> src_level == 60'h924924924924924; endproperty
	a_rst: assert property (p_rst) else $error("levels not at four after reset");
	property p_keep; !s_axi_bvalid |-> $stable(src_level); endproperty
	a_keep: assert property (p_keep) else $error("level moved without a write");
	property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
	a_bans: assert property (p_bans) else $error("late write answer");
	property p_bonce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
	a_bonce: assert property (p_bonce) else $error("write answer not closed");
	property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_rans: assert property (p_rans) else $error("late read answer");
	property p_rzero; s_axi_rvalid |-> s_axi_rdata[31:20] == 12'h0; endproperty
	a_rzero: assert property (p_rzero) else $error("upper read bits set");
	property p_rerr; s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0; endproperty
	a_rerr: assert property (p_rerr) else $error("refused read with data");
endmodule // ipr_regs_chk
bind ipr_regs ipr_regs_chk ipr_regs_chk_inst (.*);
`default_nettype wire

//--- tb/ipr_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module ipr_regs_test;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [19:0] src_flag, src_req;
	logic [59:0] src_level, lv;
	logic [31:0] rst_v [8] = '{32'h4444, 32'h44, 32'h4444, 32'h4404, 32'h4440, 32'h4444, 32'h0, 32'h0};
	logic [31:0] msk [8] = '{32'h7777, 32'h77, 32'h7777, 32'h7707, 32'h7770, 32'h7777, 32'hFFFFF, 32'h0};
	// register index and field lsb of each source
	logic [7:0] pos [20] = '{8'h0C, 8'h08, 8'h04, 8'h00, 8'h14, 8'h10, 8'h2C, 8'h28, 8'h24, 8'h20,
		8'h3C, 8'h38, 8'h30, 8'h4C, 8'h48, 8'h44, 8'h5C, 8'h58, 8'h54, 8'h50};
	int bad_count, cmp_count, cyc;
	ipr_regs ipr_regs_inst (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hF), .*);
	// clock, 8 ns period
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task chk(input logic [63:0] s, e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		#1;
		while (s_axi_awvalid || s_axi_wvalid) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			#1;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		chk(s_axi_bresp, r);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		chk(s_axi_rdata, d);
		chk(s_axi_rresp, r);
	endtask
	task finish_test;
		$display("mismatches %0d compares %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			finish_test;
		end
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, src_flag} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(src_level, 60'h924924924924924);
		// reset value, writable bits and clearing of each place, unmapped last
		for (int i = 0; i < 8; i++) begin
			rs = (i < 7) ? 2'h0 : 2'h2;
			rd(8'(4*i), rst_v[i], rs);
			wr(8'(4*i), 32'hFFFFFFFF, rs);
			rd(8'(4*i), msk[i], rs);
			wr(8'(4*i), 32'h0, rs);
			rd(8'(4*i), 32'h0, rs);
		end
		rd(8'h22, 32'h0, 2'h2);
		wr(8'h18, 32'h000FFFFF, 2'h0);
		src_flag <= 20'hFFFFF;
		// one field at a time reaches only its own source
		for (int i = 0; i < 20; i++) begin
			lv = 60'h0;
			lv[3*i+:3] = 3'(i % 7 + 1);
			wr({2'h0, pos[i][7:4], 2'h0}, 32'(i % 7 + 1) << pos[i][3:0], 2'h0);
			@(posedge aclk);
			chk(src_level, lv);
			chk(src_req, 20'h1 << i);
			wr({2'h0, pos[i][7:4], 2'h0}, 32'h0, 2'h0);
		end
		wr(8'h00, 32'h1000, 2'h0);
		@(posedge aclk);
		chk(src_req, 20'h1);
		wr(8'h18, 32'h0, 2'h0);
		@(posedge aclk);
		chk(src_req, 20'h0);
		finish_test;
	end
endmodule // ipr_regs_test
`default_nettype wire
